/* verilog/lm_consts.vh */
`ifndef LM_CONSTS_VH
`define LM_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define A_FEAT 8'h00
`define A_PAGING 8'h04
`define A_CODESEL 8'h08
`define A_STATUS 8'h0C
`define A_FLG_LO 8'h10
`define A_FLG_HI 8'h14
`define A_IP_LO 8'h18
`define A_IP_HI 8'h1C
`define A_IP_ADV 8'h20
`define A_SEL 8'h24
`define A_DAT_LO 8'h28
`define A_DAT_HI 8'h2C
`define A_CMD 8'h30
`define A_PG_CHK 8'h34
`define A_SEG_CHK 8'h38
`define A_CHK_RES 8'h3C
`define A_RD_LO 8'h40
`define A_RD_HI 8'h44
// ----------------------------------------
// Bus decode
// ----------------------------------------
`define A_LOW 7:0
`define A_HIGH 31:8
`define HI_ZERO 24'h000000
`define HT_ACT 1
`define HSIZE_WORD 3'h2
`define ZERO32 32'h00000000
// ----------------------------------------
// Modes, sizes and register classes
// ----------------------------------------
`define M_LEGACY 2'h0
`define M_COMPAT 2'h1
`define M_64 2'h2
`define SZ8 2'h0
`define SZ16 2'h1
`define SZ32 2'h2
`define SZ64 2'h3
`define C_GEN 3'h0
`define C_VEC 3'h1
`define C_CTL 3'h2
`define C_DBG 3'h3
`define C_MTYPE 3'h4
`define C_MODEL 3'h5
`define CTL_LAST 4'h8
`define ARR_LAST 127
// ----------------------------------------
// Masks and wide fields
// ----------------------------------------
`define MASK0 64'h0000000000000000
`define MASK8 64'h00000000000000FF
`define MASK16 64'h000000000000FFFF
`define MASK32 64'h00000000FFFFFFFF
`define MASK64 64'hFFFFFFFFFFFFFFFF
`define LO32 31:0
`define HI32 63:32
`define IP_PAD 60'h000000000000000
`define ADV_LEN 3:0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_LME 0
`define F_LMA 1
`define PG_EN 0
`define CD_L 0
`define CD_D 1
`define CD_B 2
`define CMD_WR 0
`define S_ALL 15:0
`define S_IDX 3:0
`define S_IDX_LO 2:0
`define S_CLS 6:4
`define S_PFX 7
`define S_PW 8
`define S_PR 9
`define S_P66 10
`define S_STK 11
`define S_NEAR 12
`define S_FAR 13
`define S_ASZ 14
`define S_BYTE 15
`define ST_MODE 1:0
`define ST_OPSZ 3:2
`define ST_STK 5:4
`define ST_ERR 6
`define PC_ALL 12:0
`define PC_US 4:0
`define PC_RW 9:5
`define PC_USER 10
`define PC_WR 11
`define PC_L5 12
`define SC_ALL 12:0
`define SC_CLS 2:0
`define SC_OVER 3
`define SC_RD 4
`define SC_WRA 5
`define SC_ISWR 6
`define SC_SYS 7
`define SC_TYPE 11:8
`define SEG_SYS 3'h6
`define R_ALL 3:0
`define LVL_LEGACY 5'h03
`define LVL_LONG4 5'h0F
`define LVL_LONG5 5'h1F
`define TYPES_LEGACY 16'hDAFE
`define TYPES_LONG 16'hDA04
`endif

/* verilog/arch_reg_array.v */
`timescale 1ns/1ps
`include "lm_consts.vh"
module arch_reg_array (
    // Clock
    input wire hclk,
    // Write port
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [63:0] wr_data,
    input wire [63:0] wr_keep,
    // Read port
    input wire [6:0] rd_addr,
    output wire [63:0] rd_data
);

// ----------------------------------------
// Storage
// ----------------------------------------
// Data words carry no reset; software loads them before use
reg [63:0] mem_q [0:`ARR_LAST];

// Read is combinational; the caller registers it
assign rd_data = mem_q[rd_addr];

// Masked write keeps the bits flagged in wr_keep
always @(posedge hclk) begin
    if (wr_en) begin
        mem_q[wr_addr] <= (mem_q[wr_addr] & wr_keep) |
                          (wr_data & ~wr_keep);
    end
end

endmodule

/* verilog/prot_check.v */
`timescale 1ns/1ps
`include "lm_consts.vh"
module prot_check (
    // Mode
    input wire long_act,
    input wire mode64,
    // Requests
    input wire [12:0] pg_req,
    input wire [12:0] seg_req,
    // Verdicts
    output reg page_flt,
    output reg lim_flt,
    output reg attr_flt,
    output reg type_flt
);

// ----------------------------------------
// Page and segment checks
// ----------------------------------------
reg [4:0] lvl;
reg [4:0] deny;
reg [15:0] legal;

// Pure decode; the top samples the verdicts every cycle
always @* begin
    lvl = `LVL_LEGACY;
    if (long_act) begin
        lvl = pg_req[`PC_L5] ? `LVL_LONG5 : `LVL_LONG4;
    end
    deny = 5'h00;
    if (pg_req[`PC_USER]) begin
        deny = deny | ~pg_req[`PC_US];
    end
    if (pg_req[`PC_WR]) begin
        deny = deny | ~pg_req[`PC_RW];
    end
    page_flt = |(deny & lvl);
    lim_flt = seg_req[`SC_OVER];
    if (mode64 && (seg_req[`SC_CLS] != `SEG_SYS)) begin
        lim_flt = 1'b0;
    end
    if (seg_req[`SC_ISWR]) begin
        attr_flt = ~seg_req[`SC_WRA];
    end else begin
        attr_flt = ~seg_req[`SC_RD];
    end
    if (mode64 || (seg_req[`SC_CLS] == `SEG_SYS)) begin
        attr_flt = 1'b0;
    end
    legal = long_act ? `TYPES_LONG : `TYPES_LEGACY;
    type_flt = seg_req[`SC_SYS] & ~legal[seg_req[`SC_TYPE]];
end

endmodule

/* verilog/long_mode_regs.v */
// Functional notes
// - Long mode checks permissions at top levels
// - Legacy-only system types fail in long mode
// - 64-bit mode skips limits except system tables
// - 64-bit mode treats segments readable, writable
// - 64-bit mode: sixteen wide general registers
// - Other modes: eight 32-bit general registers
// - Vector registers 8-15 only in 64-bit mode
// - Flags upper half always reads zero
// - Instruction pointer is 64-bit in long mode
// - 64-bit mode stack pointer always 64 bits
// - Full-width control registers only in 64-bit
// - Task priority control reachable in 64-bit
// - Paging enable toggles long mode when enabled
// - Debug registers 8-15 are not implemented
// - Enable and active bits visible in any mode
// - Memory-type registers kept at full width
// - Model registers read and written full width
// - Meaningless extension prefix is ignored
// - Prefix needed only for extended or wide
// - 64-bit mode: near branches and stack ops default wide
// - 64-bit mode: default 32; wide prefix beats size prefix
// - 64-bit mode: 32-bit writes zero-extend; narrower preserve
// - Long code descriptor enters 64-bit mode
`timescale 1ns/1ps
`include "lm_consts.vh"
module long_mode_regs (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite request
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    // AHB-Lite answer
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    // Mode indication
    output wire long_mode_active
);

// ----------------------------------------
// Decode functions
// ----------------------------------------
// Operand size from mode, prefixes and instruction group
function [1:0] op_size;
    input m64;
    input [15:0] s;
    input d;
    begin
        if (s[`S_BYTE]) begin
            op_size = `SZ8;
        end else if (m64) begin
            if (s[`S_PFX] & s[`S_PW]) begin
                op_size = `SZ64;
            end else if (s[`S_P66]) begin
                op_size = `SZ16;
            end else if ((s[`S_STK] | s[`S_NEAR]) & ~s[`S_FAR]) begin
                op_size = `SZ64;
            end else begin
                op_size = `SZ32;
            end
        end else begin
            op_size = (d ^ s[`S_P66]) ? `SZ32 : `SZ16;
        end
    end
endfunction

// Bit mask covering an operand of the given size
function [63:0] size_mask;
    input [1:0] sz;
    begin
        case (sz)
            `SZ8: size_mask = `MASK8;
            `SZ16: size_mask = `MASK16;
            `SZ32: size_mask = `MASK32;
            default: size_mask = `MASK64;
        endcase
    end
endfunction

// ----------------------------------------
// Bus phase tracking
// ----------------------------------------
reg [7:0] addr_q;
reg map_q;
reg wr_q;
reg rd_q;
reg hreadyout_q;
reg hresp_q;
reg [31:0] hrdata_q;
reg [31:0] rd_mux;
wire take;

// Address phase is taken only while the bus is ready
assign take = hsel & htrans[`HT_ACT] & hready;

// ----------------------------------------
// Architectural state
// ----------------------------------------
reg lme_q;
reg lma_q;
reg pg_q;
reg cs_l_q;
reg cs_d_q;
reg ss_b_q;
reg [31:0] flg_q;
reg [63:0] ip_q;
reg [15:0] sel_q;
reg [63:0] dat_q;
reg [12:0] pgc_q;
reg [12:0] sgc_q;
reg [3:0] res_q;
reg [63:0] rdv_q;
reg err_q;

// Mode derives from the active bit and the code long attribute
wire m64;
wire [1:0] mode;
assign m64 = lma_q & cs_l_q;
assign mode = m64 ? `M_64 : (lma_q ? `M_COMPAT : `M_LEGACY);

// ----------------------------------------
// Write strobes in the data phase
// ----------------------------------------
wire we;
wire cmd_go;
assign we = wr_q & map_q;
assign cmd_go = we & (addr_q == `A_CMD);

// ----------------------------------------
// Register access decode
// ----------------------------------------
wire [1:0] opsz;
wire [1:0] stk_w;
wire [2:0] acc_cls;
wire ext_sel;
reg [3:0] acc_idx;
reg acc_ok;
reg [63:0] acc_keep;
reg [63:0] acc_rmask;
wire [63:0] arr_rd;

assign opsz = op_size(m64, sel_q, cs_d_q);
assign acc_cls = sel_q[`S_CLS];
// Extension bit counts only in 64-bit mode with the prefix
assign ext_sel = m64 & sel_q[`S_PFX] & sel_q[`S_PR];

// Stack width follows segment size bit; 64-bit mode ignores it and forces 64
assign stk_w = m64 ? `SZ64 : (ss_b_q ? `SZ32 : `SZ16);

// Index, validity and merge masks for each register class
always @* begin
    acc_idx = sel_q[`S_IDX];
    acc_ok = 1'b1;
    acc_keep = `MASK0;
    acc_rmask = `MASK64;
    case (acc_cls)
        `C_GEN: begin
            acc_idx = {ext_sel, sel_q[`S_IDX_LO]};
            acc_rmask = size_mask(opsz);
            if (~m64 | (opsz == `SZ8) | (opsz == `SZ16)) begin
                acc_keep = ~acc_rmask;
            end
        end
        `C_VEC: begin
            acc_idx = {ext_sel, sel_q[`S_IDX_LO]};
        end
        `C_CTL, `C_DBG: begin
            acc_idx = {ext_sel, sel_q[`S_IDX_LO]};
            if (acc_cls == `C_DBG) begin
                acc_ok = ~acc_idx[3];
            end else begin
                acc_ok = (acc_idx <= `CTL_LAST);
            end
            // Outside 64-bit mode only the low half is reachable
            if (~m64) begin
                acc_keep = ~`MASK32;
                acc_rmask = `MASK32;
            end
        end
        `C_MTYPE: begin
            acc_idx = sel_q[`S_IDX];
        end
        `C_MODEL: begin
            acc_idx = sel_q[`S_IDX];
        end
        default: begin
            acc_ok = 1'b0;
        end
    endcase
end

// ----------------------------------------
// Register arrays and checker
// ----------------------------------------
// One array serves every class; the class forms the top bits
arch_reg_array i_arch_reg_array (
    .hclk(hclk),
    .wr_en(cmd_go & hwdata[`CMD_WR] & acc_ok),
    .wr_addr({acc_cls, acc_idx}),
    .wr_data(dat_q & acc_rmask),
    .wr_keep(acc_keep),
    .rd_addr({acc_cls, acc_idx}),
    .rd_data(arr_rd)
);

wire page_flt;
wire lim_flt;
wire attr_flt;
wire type_flt;

prot_check i_prot_check (
    .long_act(lma_q),
    .mode64(m64),
    .pg_req(pgc_q),
    .seg_req(sgc_q),
    .page_flt(page_flt),
    .lim_flt(lim_flt),
    .attr_flt(attr_flt),
    .type_flt(type_flt)
);

// ----------------------------------------
// Instruction pointer arithmetic
// ----------------------------------------
wire [63:0] adv_len;
wire [63:0] ip_wide;
wire [31:0] ip_narrow;
assign adv_len = {`IP_PAD, hwdata[`ADV_LEN]};
assign ip_wide = ip_q + adv_len;
assign ip_narrow = ip_q[`LO32] + adv_len[`LO32];

// ----------------------------------------
// Bus handshake and read data
// ----------------------------------------
// Reads take one wait state so hrdata comes from a flop
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        addr_q <= 8'h00;
        map_q <= 1'b0;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        hreadyout_q <= 1'b1;
        hresp_q <= 1'b0;
        hrdata_q <= `ZERO32;
    end else begin
        wr_q <= take & hwrite & (hsize == `HSIZE_WORD);
        rd_q <= take & ~hwrite;
        hresp_q <= 1'b0;
        if (take) begin
            addr_q <= haddr[`A_LOW];
            map_q <= (haddr[`A_HIGH] == `HI_ZERO);
        end
        if (take & ~hwrite) begin
            hreadyout_q <= 1'b0;
        end else if (rd_q) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= rd_mux;
        end
    end
end

// Read multiplexer; unmapped offsets read as zero
always @* begin
    rd_mux = `ZERO32;
    if (map_q) begin
        case (addr_q)
            `A_FEAT: begin
                rd_mux[`F_LME] = lme_q;
                rd_mux[`F_LMA] = lma_q;
            end
            `A_PAGING: rd_mux[`PG_EN] = pg_q;
            `A_CODESEL: begin
                rd_mux[`CD_L] = cs_l_q;
                rd_mux[`CD_D] = cs_d_q;
                rd_mux[`CD_B] = ss_b_q;
            end
            `A_STATUS: begin
                rd_mux[`ST_MODE] = mode;
                rd_mux[`ST_OPSZ] = opsz;
                rd_mux[`ST_STK] = stk_w;
                rd_mux[`ST_ERR] = err_q;
            end
            `A_FLG_LO: rd_mux = flg_q;
            `A_FLG_HI: rd_mux = `ZERO32;
            `A_IP_LO: rd_mux = ip_q[`LO32];
            `A_IP_HI: rd_mux = ip_q[`HI32];
            `A_SEL: rd_mux[`S_ALL] = sel_q;
            `A_DAT_LO: rd_mux = dat_q[`LO32];
            `A_DAT_HI: rd_mux = dat_q[`HI32];
            `A_PG_CHK: rd_mux[`PC_ALL] = pgc_q;
            `A_SEG_CHK: rd_mux[`SC_ALL] = sgc_q;
            `A_CHK_RES: rd_mux[`R_ALL] = res_q;
            `A_RD_LO: rd_mux = rdv_q[`LO32];
            `A_RD_HI: rd_mux = rdv_q[`HI32];
            default: rd_mux = `ZERO32;
        endcase
    end
end

// ----------------------------------------
// Mode control and register writes
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        lme_q <= 1'b0;
        lma_q <= 1'b0;
        pg_q <= 1'b0;
        cs_l_q <= 1'b0;
        cs_d_q <= 1'b0;
        ss_b_q <= 1'b0;
        flg_q <= `ZERO32;
        ip_q <= `MASK0;
        sel_q <= 16'h0000;
        dat_q <= `MASK0;
        pgc_q <= 13'h0000;
        sgc_q <= 13'h0000;
        res_q <= 4'h0;
        rdv_q <= `MASK0;
        err_q <= 1'b0;
    end else begin
        // Verdicts follow the stored requests every cycle
        res_q <= {type_flt, attr_flt, lim_flt, page_flt};
        if (we) begin
            case (addr_q)
                `A_FEAT: begin
                    // Enable may not change under paging; avoids
                    // a mode flip without a paging transition
                    if (!pg_q) begin
                        lme_q <= hwdata[`F_LME];
                    end
                end
                `A_PAGING: begin
                    pg_q <= hwdata[`PG_EN];
                    lma_q <= lme_q & hwdata[`PG_EN];
                    if (!hwdata[`PG_EN]) begin
                        cs_l_q <= 1'b0;
                    end
                end
                `A_CODESEL: begin
                    // Long attribute is reserved outside long mode
                    cs_l_q <= lma_q & hwdata[`CD_L];
                    cs_d_q <= hwdata[`CD_D];
                    ss_b_q <= hwdata[`CD_B];
                end
                `A_FLG_LO: flg_q <= hwdata;
                `A_FLG_HI: flg_q <= flg_q;
                `A_IP_LO: begin
                    ip_q[`LO32] <= hwdata;
                    if (!lma_q) begin
                        ip_q[`HI32] <= `ZERO32;
                    end
                end
                `A_IP_HI: begin
                    if (lma_q) begin
                        ip_q[`HI32] <= hwdata;
                    end
                end
                `A_IP_ADV: begin
                    if (lma_q) begin
                        ip_q <= ip_wide;
                    end else begin
                        ip_q <= {`ZERO32, ip_narrow};
                    end
                end
                `A_SEL: sel_q <= hwdata[`S_ALL];
                `A_DAT_LO: dat_q[`LO32] <= hwdata;
                `A_DAT_HI: dat_q[`HI32] <= hwdata;
                `A_PG_CHK: pgc_q <= hwdata[`PC_ALL];
                `A_SEG_CHK: sgc_q <= hwdata[`SC_ALL];
                `A_CMD: begin
                    err_q <= ~acc_ok;
                    // Reads show old contents; invalid reads give zero
                    if (acc_ok) begin
                        rdv_q <= arr_rd & acc_rmask;
                    end else begin
                        rdv_q <= `MASK0;
                    end
                end
                default: begin
                    err_q <= err_q;
                end
            endcase
        end
    end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign hreadyout = hreadyout_q;
assign hrdata = hrdata_q;
assign hresp = hresp_q;
assign long_mode_active = lma_q;

endmodule

/* test/long_mode_regs_chk.sv */
`timescale 1ns/1ps
`include "lm_consts.vh"
module long_mode_regs_chk (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus request
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    // Bus answer and mode
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire hresp,
    input wire long_mode_active
);
    // ----------------------------------------
    // Transfer tracking
    // ----------------------------------------
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    wire take = hsel & htrans[1] & hready;
    wire rd_take = take & ~hwrite;
    wire mapped = (haddr[31:8] == 24'h000000);

    // Remember the write in its data phase, when hwdata is valid
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take & hwrite & mapped & (hsize == 3'h2);
            wr_addr_q <= haddr[7:0];
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    chk_read_one_wait: assert property (
        rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_unmapped_zero: assert property (
        rd_take && !mapped |-> ##2 hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_flags_upper_zero: assert property (
        rd_take && mapped && haddr[7:0] == `A_FLG_HI
        |-> ##2 hrdata == 32'h00000000)
        else $error("upper flags not zero");
    chk_active_bit_seen: assert property (
        rd_take && mapped && haddr[7:0] == `A_FEAT
        |-> ##2 hrdata[1] == long_mode_active)
        else $error("active bit mismatch");
    chk_paging_off_exit: assert property (
        wr_pend_q && wr_addr_q == `A_PAGING && !hwdata[0]
        |=> !long_mode_active)
        else $error("long mode kept after paging off");
    chk_active_cause: assert property (
        $rose(long_mode_active)
        |-> $past(wr_pend_q) && $past(wr_addr_q) == `A_PAGING)
        else $error("long mode entered without paging write");
    chk_result_pad: assert property (
        rd_take && mapped && haddr[7:0] == `A_CHK_RES
        |-> ##2 hrdata[31:4] == 28'h0000000)
        else $error("check result upper bits set");

    cover property (rd_take ##2 hrdata != 32'h00000000);
    cover property ($rose(long_mode_active));
    cover property ($fell(long_mode_active));
endmodule

bind long_mode_regs long_mode_regs_chk i_long_mode_regs_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .long_mode_active(long_mode_active)
);

/* test/long_mode_regs_bench.sv */
`timescale 1ns/1ps
`include "lm_consts.vh"
module long_mode_regs_bench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, long_mode_active;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int num_errors, checks;
    logic [15:0] sels [9] = '{16'h0000, 16'h0400, 16'h0580, 16'h0080,
        16'h0800, 16'h1000, 16'h2800, 16'h4000, 16'h8000};
    logic [1:0] szs [9] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h3, 2'h3, 2'h2,
        2'h2, 2'h0};

    long_mode_regs i_long_mode_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp),
        .long_mode_active(long_mode_active)
    );

    // Free-running bus clock, 40 ns
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task close_out;
        begin
            $display("checks %0d errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checks++;
            if (g !== e) begin
                num_errors++;
                $display("ERROR %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // Sampled right after the edge, so this is the pre-edge ready
    task wait_ready;
        int n;
        begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (n >= 50) begin
                num_errors++;
                $display("ERROR hready expected 1 seen %b", hreadyout);
                close_out;
            end
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_ready;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_ready;
            v = hrdata;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, {24'h000000, a}, d);
    endtask

    task chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        begin
            bus(1'b0, {24'h000000, a}, 32'h00000000);
            cmp(nm, e, v);
        end
    endtask

    // One array access: select, operand words, then command
    task acc(input logic [15:0] s, input logic c, input logic [31:0] lo,
             input logic [31:0] hi);
        begin
            wr(`A_SEL, {16'h0000, s});
            wr(`A_DAT_LO, lo);
            wr(`A_DAT_HI, hi);
            wr(`A_CMD, {31'h00000000, c});
            // A write command latches the old word, so read it back
            if (c) begin
                wr(`A_CMD, 32'h00000000);
            end
        end
    endtask

    task res(input logic [31:0] lo, input logic [31:0] hi);
        begin
            chk("rd_lo", `A_RD_LO, lo);
            chk("rd_hi", `A_RD_HI, hi);
        end
    endtask

    task stat(input string nm, input logic [1:0] lsb, input logic [31:0] e);
        begin
            bus(1'b0, {24'h000000, `A_STATUS}, 32'h00000000);
            // Field n of the status word starts at bit 2n
            cmp(nm, e, (v >> (lsb * 2)) & ((lsb == 2'h3) ? 32'h1 : 32'h3));
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        num_errors = 0;
        checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk("feat", `A_FEAT, 32'h00000000);
        stat("mode", 2'h0, 32'h0);
        // Legacy mode
        wr(`A_FLG_LO, 32'hFFFFFFFF);
        wr(`A_FLG_HI, 32'hFFFFFFFF);
        chk("flg_lo", `A_FLG_LO, 32'hFFFFFFFF);
        chk("flg_hi", `A_FLG_HI, 32'h00000000);
        bus(1'b1, 32'h00000100, 32'h00000001);
        chk("feat", `A_FEAT, 32'h00000000);
        bus(1'b0, 32'h00000100, 32'h00000000);
        cmp("unmapped", 32'h00000000, v);
        wr(`A_IP_LO, 32'hFFFFFFFE);
        wr(`A_IP_ADV, 32'h00000003);
        chk("ip_lo", `A_IP_LO, 32'h00000001);
        chk("ip_hi", `A_IP_HI, 32'h00000000);
        wr(`A_CODESEL, 32'h00000002);
        acc(16'h0280, 1'b1, 32'h12345678, 32'hAAAAAAAA);
        acc(16'h0000, 1'b0, 32'h0, 32'h0);
        res(32'h12345678, 32'h00000000);
        acc(16'h0040, 1'b1, 32'hDEADBEEF, 32'h01234567);
        res(32'hDEADBEEF, 32'h01234567);
        acc(16'h0053, 1'b1, 32'h76543210, 32'h89ABCDEF);
        res(32'h76543210, 32'h89ABCDEF);
        // Readable descriptor, so only the type check can trip
        wr(`A_SEG_CHK, 32'h00000190);
        chk("type", `A_CHK_RES, 32'h00000000);
        wr(`A_PG_CHK, 32'h000007F7);
        chk("page", `A_CHK_RES, 32'h00000000);
        wr(`A_PG_CHK, 32'h00000000);
        $display("test legacy done");
        // Compatibility sub-mode
        wr(`A_FEAT, 32'h00000001);
        wr(`A_PAGING, 32'h00000001);
        chk("feat", `A_FEAT, 32'h00000003);
        cmp("lma_pin", 32'h00000001, {31'h0, long_mode_active});
        stat("mode", 2'h0, 32'h1);
        wr(`A_SEG_CHK, 32'h00000190);
        chk("type", `A_CHK_RES, 32'h00000008);
        wr(`A_SEG_CHK, 32'h00000018);
        chk("limit", `A_CHK_RES, 32'h00000002);
        wr(`A_SEG_CHK, 32'h00000040);
        chk("attr", `A_CHK_RES, 32'h00000004);
        chk("page", `A_CHK_RES, 32'h00000004);
        wr(`A_PG_CHK, 32'h000007F7);
        // The attribute fault of the write request still stands
        chk("page", `A_CHK_RES, 32'h00000005);
        wr(`A_PG_CHK, 32'h00000000);
        acc(16'h0020, 1'b1, 32'h11111111, 32'h22222222);
        res(32'h11111111, 32'h00000000);
        stat("stack", 2'h2, 32'h1);
        $display("test compat done");
        // 64-bit sub-mode
        wr(`A_CODESEL, 32'h00000003);
        stat("mode", 2'h0, 32'h2);
        stat("stack", 2'h2, 32'h3);
        wr(`A_SEG_CHK, 32'h00000018);
        chk("limit", `A_CHK_RES, 32'h00000000);
        wr(`A_SEG_CHK, 32'h0000000E);
        chk("limit", `A_CHK_RES, 32'h00000002);
        wr(`A_SEG_CHK, 32'h00000040);
        chk("attr", `A_CHK_RES, 32'h00000000);
        wr(`A_SEG_CHK, 32'h00000180);
        chk("type", `A_CHK_RES, 32'h00000008);
        for (int i = 0; i < 9; i++) begin
            wr(`A_SEL, {16'h0000, sels[i]});
            stat("opsz", 2'h1, {30'h0, szs[i]});
        end
        acc(16'h0381, 1'b1, 32'h22222222, 32'h11111111);
        acc(16'h0001, 1'b1, 32'h33333333, 32'h44444444);
        res(32'h33333333, 32'h00000000);
        acc(16'h0381, 1'b0, 32'h0, 32'h0);
        res(32'h22222222, 32'h11111111);
        acc(16'h0182, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF);
        acc(16'h0402, 1'b1, 32'h00001234, 32'h0);
        acc(16'h0182, 1'b0, 32'h0, 32'h0);
        res(32'hFFFF1234, 32'hFFFFFFFF);
        acc(16'h0002, 1'b1, 32'h00000005, 32'h0);
        acc(16'h0182, 1'b0, 32'h0, 32'h0);
        res(32'h00000005, 32'h00000000);
        acc(16'h0011, 1'b1, 32'hAAAA0001, 32'h0);
        acc(16'h0291, 1'b1, 32'hBBBB0009, 32'h0);
        acc(16'h0011, 1'b0, 32'h0, 32'h0);
        res(32'hAAAA0001, 32'h00000000);
        acc(16'h02B0, 1'b1, 32'h00000001, 32'h0);
        stat("err", 2'h3, 32'h1);
        acc(16'h03A0, 1'b1, 32'h0000000F, 32'h0);
        stat("err", 2'h3, 32'h0);
        res(32'h0000000F, 32'h00000000);
        wr(`A_IP_LO, 32'hFFFFFFFF);
        wr(`A_IP_HI, 32'h00000000);
        wr(`A_IP_ADV, 32'h00000001);
        chk("ip_lo", `A_IP_LO, 32'h00000000);
        chk("ip_hi", `A_IP_HI, 32'h00000001);
        wr(`A_PAGING, 32'h00000000);
        chk("feat", `A_FEAT, 32'h00000001);
        cmp("lma_pin", 32'h00000000, {31'h0, long_mode_active});
        stat("mode", 2'h0, 32'h0);
        $display("test long done");
        close_out;
    end
endmodule
